// ==== design/half_timer.sv ====
`timescale 1ns/10ps
module half_timer
   import twc_pkg::*;
#(
   parameter int CNT_W = 16
) (
   input  wire logic   hclk,
   input  wire logic   hresetn,
   input  wire logic   go,
   input  wire logic   high,
   input  wire shape_t shape,
   output logic        done
);
   logic [CNT_W-1:0] cnt_q;
   logic             run_q;
   logic [CNT_W-1:0] len;

   // 255 shifted by 7 plus 3 needs 15 bits
   if (CNT_W < 16) begin : g_chk
      $error("half_timer counter too narrow");
   end

   always_comb begin
      len = (CNT_W'(high ? shape.hi : shape.lo) << shape.exp) + CNT_W'(EDGE_ADD);
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_q <= '0;
         run_q <= 1'b0;
      end else if (go) begin
         cnt_q <= len - CNT_W'(1);
         run_q <= 1'b1;
      end else if (run_q) begin
         if (cnt_q == '0) begin
            run_q <= 1'b0;
         end else begin
            cnt_q <= cnt_q - CNT_W'(1);
         end
      end
   end

   assign done = run_q && (cnt_q == '0);
endmodule : half_timer

// ==== design/line_sync.sv ====
`timescale 1ns/10ps
module line_sync #(
   parameter int STAGES = 2
) (
   input  wire logic hclk,
   input  wire logic hresetn,
   input  wire logic d,
   output logic      q
);
   logic [STAGES-1:0] ff_q;

   if (STAGES < 2) begin : g_chk
      $error("line_sync needs at least two stages");
   end

   // Idle bus floats high, so reset to ones
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ff_q <= '1;
      end else begin
         ff_q <= {ff_q[STAGES-2:0], d};
      end
   end

   assign q = ff_q[STAGES-1];
endmodule : line_sync

// ==== design/two_wire_controller.sv ====
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/10ps
module two_wire_controller
   import twc_pkg::*;
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [7:0]  haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        scl_i,
   output logic             scl_o,
   output logic             scl_oe,
   input  wire logic        sda_i,
   output logic             sda_o,
   output logic             sda_oe,
   output logic             irq
);
   link_st_t          state_q, state_d;
   setup_t            setup_q;
   shape_t            shape_q;
   logic [23:0]       inner_q;
   logic [FLAG_W-1:0] imr_q, flags;
   logic [7:0]        thr_q, rhr_q, sh_q, adr_q;
   logic [3:0]        bit_q;
   logic [1:0]        iad_left_q;
   logic [31:0]       hrdata_q;
   logic        wr_q, srst_q, rst_n, acc, rd_acc, rd_rx, rd_fl;
   logic        wcmd, start_w, stop_w, on_w, off_w, thr_w;
   logic        on_q, off_req_q, start_pend_q, stop_pend_q, thr_full_q;
   logic        hdr_q, rx_q, rd_dev_q, mack_q, not_acknowledged_flag_hit_q, irq_q;
   logic        transfer_complete_flag_q, receive_ready_flag_q, transmit_ready_flag_q, not_acknowledged_flag_q, ovre_q, unre_q;
   logic        scl_s, sda_s, t_done, t_go, t_high, launch, fin, slot_end;
   logic        ld_iad, ld_thr, ld_rx, rep_go, stop_go, e_not_acknowledged_flag, e_unre, e_rx, e_ack;
   logic        scl_oe_q, sda_oe_q, sda_low;

   function automatic logic [7:0] iad_byte(input logic [1:0] n, input logic [23:0] a);
      unique case (n)
         2'd3:    iad_byte = a[23:16];
         2'd2:    iad_byte = a[15:8];
         default: iad_byte = a[7:0];
      endcase
   endfunction : iad_byte

   function automatic logic [31:0] reg_read(input logic [7:0] a);
      unique case (a)
         OFS_SETUP:   reg_read = 32'({setup_q.dev, 3'b000, setup_q.rd, 2'b00, setup_q.isz,
                                     8'h00});
         OFS_INNER:   reg_read = 32'(inner_q);
         OFS_SHAPE:   reg_read = 32'(shape_q);
         OFS_FLAGS:   reg_read = 32'(flags) | FLAGS_FIXED;
         OFS_IRQ_MAP: reg_read = 32'(imr_q);
         OFS_RX:      reg_read = 32'(rhr_q);
         OFS_TX:      reg_read = 32'(thr_q);
         default:     reg_read = REG_RESET;
      endcase
   endfunction : reg_read

   // Bus slave: zero wait, always OKAY
   assign acc       = hsel && htrans[1] && hready;
   assign rd_acc    = acc && !hwrite;
   assign rd_rx     = rd_acc && (haddr == OFS_RX);
   assign rd_fl     = rd_acc && (haddr == OFS_FLAGS);
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = hrdata_q;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_q     <= 1'b0;
         adr_q    <= 8'h00;
         hrdata_q <= REG_RESET;
      end else begin
         wr_q  <= acc && hwrite && (hsize == HSIZE_WORD);
         adr_q <= haddr;
         if (rd_acc) begin
            hrdata_q <= reg_read(haddr);
         end
      end
   end

   // Soft reset pulse; bus side survives it so the write completes
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         srst_q <= 1'b0;
      end else begin
         srst_q <= wcmd && hwdata[CMD_SRST];
      end
   end
   assign rst_n = hresetn && !srst_q;

   assign wcmd    = wr_q && (adr_q == OFS_CMD);
   assign start_w = wcmd && hwdata[CMD_START];
   assign stop_w  = wcmd && hwdata[CMD_STOP];
   assign on_w    = wcmd && hwdata[CMD_ON] && !hwdata[CMD_OFF];
   assign off_w   = wcmd && hwdata[CMD_OFF];
   assign thr_w   = wr_q && (adr_q == OFS_TX);

   always_ff @(posedge hclk or negedge rst_n) begin
      if (!rst_n) begin
         setup_q <= setup_t'(REG_RESET);
         inner_q <= 24'(REG_RESET);
         shape_q <= shape_t'(REG_RESET);
         thr_q   <= 8'(REG_RESET);
         imr_q   <= FLAG_W'(REG_RESET);
      end else if (wr_q) begin
         unique case (adr_q)
            OFS_SETUP:   setup_q <= '{dev: hwdata[SETUP_DEV_LSB +: 7],
                                      rd:  hwdata[SETUP_RD_BIT],
                                      isz: hwdata[SETUP_ISZ_LSB +: 2]};
            OFS_INNER:   inner_q <= hwdata[23:0];
            OFS_SHAPE:   shape_q <= shape_t'(hwdata[18:0]);
            OFS_TX:      thr_q   <= hwdata[7:0];
            OFS_IRQ_SET: imr_q   <= imr_q | hwdata[FLAG_W-1:0];
            OFS_IRQ_CLR: imr_q   <= imr_q & ~hwdata[FLAG_W-1:0];
            default:     ;
         endcase
      end
   end

   line_sync u_scl_sync (
      .hclk    (hclk),
      .hresetn (hresetn),
      .d       (scl_i),
      .q       (scl_s)
   );
   line_sync u_sda_sync (
      .hclk    (hclk),
      .hresetn (hresetn),
      .d       (sda_i),
      .q       (sda_s)
   );

   // Reload on every state change except into ST_IDLE; a held-low clock re-arms the high half in ST_BHIGH only
   assign t_go   = (state_d != state_q && state_d != ST_IDLE)
                || (state_q == ST_BHIGH && t_done && !scl_s);
   assign t_high = !(state_d inside {ST_BLOW, ST_RLOW, ST_PLOW});
   half_timer u_timer (
      .hclk    (hclk),
      .hresetn (rst_n),
      .go      (t_go),
      .high    (t_high),
      .shape   (shape_q),
      .done    (t_done)
   );

   assign launch   = (state_q == ST_IDLE) && on_q && !off_req_q && start_pend_q
                   && (setup_q.rd || thr_full_q);
   assign fin      = (state_q == ST_PEND) && t_done;
   assign slot_end = (state_q == ST_BHIGH) && t_done && scl_s && (bit_q == ACK_SLOT);

   always_comb begin
      state_d = state_q;
      ld_iad  = 1'b0;
      ld_thr  = 1'b0;
      ld_rx   = 1'b0;
      rep_go  = 1'b0;
      stop_go = 1'b0;
      e_not_acknowledged_flag  = 1'b0;
      e_unre  = 1'b0;
      e_rx    = 1'b0;
      e_ack   = 1'b0;
      unique case (state_q)
         ST_IDLE:  if (launch) state_d = ST_START;
         ST_START: if (t_done) state_d = ST_BLOW;
         ST_BLOW:  if (t_done) state_d = ST_BHIGH;
         ST_RLOW:  if (t_done) state_d = ST_RHIGH;
         ST_RHIGH: if (t_done) state_d = ST_START;
         ST_PLOW:  if (t_done) state_d = ST_PHIGH;
         ST_PHIGH: if (t_done) state_d = ST_PEND;
         ST_PEND:  if (t_done) state_d = ST_IDLE;
         ST_BHIGH: begin
            if (t_done && scl_s && bit_q != ACK_SLOT) begin
               state_d = ST_BLOW;
            end else if (slot_end) begin
               if (rx_q) begin
                  e_rx    = 1'b1;
                  stop_go = mack_q == 1'b0;
                  ld_rx   = mack_q;
               end else if (sda_s) begin
                  e_not_acknowledged_flag  = 1'b1;
                  stop_go = 1'b1;
               end else if (hdr_q && iad_left_q != 2'd0) begin
                  ld_iad = 1'b1;
               end else if (hdr_q && setup_q.rd && !rd_dev_q) begin
                  rep_go = 1'b1;
               end else if (hdr_q && setup_q.rd) begin
                  ld_rx = 1'b1;
               end else begin
                  e_ack = !hdr_q;
                  // Header end ignores stop so start+stop still sends one byte
                  if (stop_pend_q && !hdr_q) begin
                     stop_go = 1'b1;
                  end else if (thr_full_q) begin
                     ld_thr = 1'b1;
                  end else begin
                     e_unre  = 1'b1;
                     stop_go = 1'b1;
                  end
               end
               state_d = stop_go ? ST_PLOW : (rep_go ? ST_RLOW : ST_BLOW);
            end
         end
      endcase
   end

   always_ff @(posedge hclk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // Byte engine
   always_ff @(posedge hclk or negedge rst_n) begin
      if (!rst_n) begin
         sh_q       <= 8'h00;
         bit_q      <= 4'h0;
         hdr_q      <= 1'b0;
         rx_q       <= 1'b0;
         rd_dev_q   <= 1'b0;
         mack_q     <= 1'b0;
         iad_left_q <= 2'd0;
         rhr_q      <= 8'(REG_RESET);
      end else begin
         if (launch) begin
            sh_q       <= {setup_q.dev, setup_q.rd && setup_q.isz == 2'd0};
            rd_dev_q   <= setup_q.rd && setup_q.isz == 2'd0;
            iad_left_q <= setup_q.isz;
            bit_q      <= 4'h0;
            hdr_q      <= 1'b1;
            rx_q       <= 1'b0;
         end else if (rep_go) begin
            sh_q     <= {setup_q.dev, 1'b1};
            rd_dev_q <= 1'b1;
            bit_q    <= 4'h0;
         end else if (ld_iad) begin
            sh_q       <= iad_byte(iad_left_q, inner_q);
            iad_left_q <= iad_left_q - 2'd1;
            bit_q      <= 4'h0;
         end else if (ld_thr) begin
            sh_q  <= thr_q;
            hdr_q <= 1'b0;
            bit_q <= 4'h0;
         end else if (ld_rx) begin
            sh_q  <= 8'hFF;
            hdr_q <= 1'b0;
            rx_q  <= 1'b1;
            bit_q <= 4'h0;
         end else if (state_q == ST_BHIGH && t_done && scl_s && bit_q != ACK_SLOT) begin
            sh_q  <= {sh_q[6:0], sda_s};
            bit_q <= bit_q + 4'h1;
            // Ack choice frozen here so a late stop cannot glitch the slot
            mack_q <= rx_q && !stop_pend_q;
         end
         if (e_rx) begin
            rhr_q <= sh_q;
         end
      end
   end

   // Command and holding state
   always_ff @(posedge hclk or negedge rst_n) begin
      if (!rst_n) begin
         on_q         <= 1'b0;
         off_req_q    <= 1'b0;
         start_pend_q <= 1'b0;
         stop_pend_q  <= 1'b0;
         thr_full_q   <= 1'b0;
         not_acknowledged_flag_hit_q   <= 1'b0;
      end else begin
         if (on_w) begin
            on_q <= 1'b1;
         end else if (off_req_q && state_q == ST_IDLE) begin
            on_q <= 1'b0;
         end
         off_req_q    <= off_w || (off_req_q && !on_w && state_q != ST_IDLE);
         start_pend_q <= start_w || (start_pend_q && !launch);
         stop_pend_q  <= stop_w || (stop_pend_q && !fin);
         thr_full_q   <= thr_w || (thr_full_q && !ld_thr);
         not_acknowledged_flag_hit_q   <= e_not_acknowledged_flag || (not_acknowledged_flag_hit_q && !fin);
      end
   end

   // Status flags: a set in the same cycle as a clear wins
   always_ff @(posedge hclk or negedge rst_n) begin
      if (!rst_n) begin
         transfer_complete_flag_q <= 1'b0;
         receive_ready_flag_q  <= 1'b0;
         transmit_ready_flag_q  <= 1'b0;
         not_acknowledged_flag_q   <= 1'b0;
         ovre_q   <= 1'b0;
         unre_q   <= 1'b0;
      end else begin
         transfer_complete_flag_q <= fin || on_w || (transfer_complete_flag_q && !launch);
         receive_ready_flag_q  <= e_rx || (receive_ready_flag_q && !rd_rx);
         transmit_ready_flag_q  <= e_ack || ld_thr || on_w || (fin && not_acknowledged_flag_hit_q)
                  || (transmit_ready_flag_q && !thr_w);
         not_acknowledged_flag_q   <= (fin && not_acknowledged_flag_hit_q) || (not_acknowledged_flag_q && !rd_fl);
         ovre_q   <= (e_rx && receive_ready_flag_q) || (ovre_q && !(rd_fl && transfer_complete_flag_q));
         unre_q   <= e_unre || (unre_q && !(rd_fl && transfer_complete_flag_q));
      end
   end

   assign flags = {not_acknowledged_flag_q, unre_q, ovre_q, 3'b000, transmit_ready_flag_q, receive_ready_flag_q, transfer_complete_flag_q};

   always_ff @(posedge hclk or negedge rst_n) begin
      if (!rst_n) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(flags & imr_q);
      end
   end
   assign irq = irq_q;

   // Clock falls on the state edge, data follows one cycle later
   always_comb begin
      sda_low = 1'b0;
      unique case (state_q)
         ST_START, ST_PLOW, ST_PHIGH: sda_low = 1'b1;
         ST_BLOW, ST_BHIGH:
            sda_low = (bit_q == ACK_SLOT) ? mack_q : (!rx_q && !sh_q[7]);
         default: sda_low = 1'b0;
      endcase
   end

   always_ff @(posedge hclk or negedge rst_n) begin
      if (!rst_n) begin
         scl_oe_q <= 1'b0;
         sda_oe_q <= 1'b0;
      end else begin
         scl_oe_q <= state_d inside {ST_BLOW, ST_RLOW, ST_PLOW};
         sda_oe_q <= sda_low;
      end
   end

   // Open drain: only ever pull low
   assign scl_o  = 1'b0;
   assign sda_o  = 1'b0;
   assign scl_oe = scl_oe_q;
   assign sda_oe = sda_oe_q;

   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!rst_n);

   sequence s_open;
      state_q == ST_START ##1 (sda_oe && !scl_oe);
   endsequence
   sequence s_close;
      state_q == ST_PLOW ##1 (scl_oe && sda_oe);
   endsequence

   a_bus_free: assert property ((state_q == ST_IDLE && $past(state_q) == ST_IDLE)
      |-> (!scl_oe && !sda_oe)) else $error("bus not released when idle");
   a_start_edge: assert property ((!scl_oe && $rose(sda_oe))
      |-> $past(state_q) == ST_START) else $error("data fell outside start");
   a_stop_edge: assert property ((!scl_oe && $fell(sda_oe))
      |-> $past(state_q) == ST_PEND) else $error("data rose outside stop");
   a_frame_open: assert property (launch |=> s_open)
      else $error("start did not open frame");
   a_dev_byte: assert property (launch |=> sh_q == {$past(setup_q.dev),
      $past(setup_q.rd) && $past(setup_q.isz) == 2'd0})
      else $error("device byte wrong");
   a_ack_release: assert property ((state_q == ST_BHIGH && bit_q == ACK_SLOT && !rx_q)
      |-> !sda_oe) else $error("master held data in ack slot");
   a_not_acknowledged_flag_stop: assert property ((slot_end && !rx_q && sda_s)
      |=> s_close) else $error("no stop after not acknowledge");
   a_not_acknowledged_flag_done: assert property ($rose(not_acknowledged_flag_q) |-> (transfer_complete_flag_q && transmit_ready_flag_q))
      else $error("not_acknowledged_flag without complete");
   a_irq_gate: assert property (irq |-> $past(|(flags & imr_q)))
      else $error("interrupt without enabled flag");
   a_tx_ready: assert property ((thr_w && !e_ack && !ld_thr && !on_w && !fin)
      |=> !transmit_ready_flag_q) else $error("transmit ready not cleared");
   a_rx_land: assert property (e_rx |=> (receive_ready_flag_q && rhr_q == $past(sh_q)))
      else $error("received byte lost");
   a_low_min: assert property ($rose(scl_oe) |-> scl_oe[*3])
      else $error("clock low shorter than three");
   a_busy_flag: assert property ((state_q == ST_BLOW) |-> !transfer_complete_flag_q)
      else $error("complete high mid frame");
   a_off_idle: assert property ((off_req_q && state_q == ST_IDLE && !on_w) |=> !on_q)
      else $error("disable did not take");
   a_on_gate: assert property ((wcmd && hwdata[CMD_OFF] && !on_q) |=> !on_q)
      else $error("enable with disable bit");
endmodule : two_wire_controller

// ==== pkg/twc_pkg.sv ====
package twc_pkg;
   localparam logic [7:0]  OFS_CMD       = 8'h00;
   localparam logic [7:0]  OFS_SETUP     = 8'h04;
   localparam logic [7:0]  OFS_INNER     = 8'h0C;
   localparam logic [7:0]  OFS_SHAPE     = 8'h10;
   localparam logic [7:0]  OFS_FLAGS     = 8'h20;
   localparam logic [7:0]  OFS_IRQ_SET   = 8'h24;
   localparam logic [7:0]  OFS_IRQ_CLR   = 8'h28;
   localparam logic [7:0]  OFS_IRQ_MAP   = 8'h2C;
   localparam logic [7:0]  OFS_RX        = 8'h30;
   localparam logic [7:0]  OFS_TX        = 8'h34;
   localparam int          CMD_START     = 0;
   localparam int          CMD_STOP      = 1;
   localparam int          CMD_ON        = 2;
   localparam int          CMD_OFF       = 3;
   localparam int          CMD_SRST      = 7;
   localparam int          SETUP_DEV_LSB = 16;
   localparam int          SETUP_RD_BIT  = 12;
   localparam int          SETUP_ISZ_LSB = 8;
   localparam int          FLAG_W        = 9;
   localparam logic [31:0] FLAGS_FIXED   = 32'h0000_0008;
   localparam logic [31:0] REG_RESET     = 32'h0000_0000;
   localparam logic [3:0]  ACK_SLOT      = 4'h8;
   localparam int          EDGE_ADD      = 3;
   localparam logic [2:0]  HSIZE_WORD    = 3'h2;

   typedef struct packed {
      logic [2:0] exp;
      logic [7:0] hi;
      logic [7:0] lo;
   } shape_t;

   typedef struct packed {
      logic [6:0] dev;
      logic       rd;
      logic [1:0] isz;
   } setup_t;

   typedef enum logic [8:0] {
      ST_IDLE  = 9'h001,
      ST_START = 9'h002,
      ST_BLOW  = 9'h004,
      ST_BHIGH = 9'h008,
      ST_RLOW  = 9'h010,
      ST_RHIGH = 9'h020,
      ST_PLOW  = 9'h040,
      ST_PHIGH = 9'h080,
      ST_PEND  = 9'h100
   } link_st_t;
endpackage : twc_pkg

// ==== verif/bus_slave_model.sv ====
`timescale 1ns/10ps
module bus_slave_model #(
   parameter logic [7:0] READ_BYTE = 8'hA5
) (
   input  wire logic scl,
   input  wire logic sda,
   input  wire logic not_acknowledged_flag_data,
   output logic      pull
);
   logic [7:0] shreg;
   logic       first;
   logic       rd;
   logic       active;
   int         bitn;
   int         stops;
   logic [7:0] got[$];

   initial begin
      pull = 1'b0;
      shreg = 8'h00;
      first = 1'b0;
      rd = 1'b0;
      active = 1'b0;
      bitn = 0;
      stops = 0;
   end

   always @(negedge sda) if (scl) begin
      active = 1'b1;
      first = 1'b1;
      rd = 1'b0;
      bitn = 0;
   end

   always @(posedge sda) if (scl && active) begin
      active = 1'b0;
      stops++;
   end

   // Read bytes shift through too, but only header and written bytes are kept
   always @(posedge scl) if (active) begin
      if (bitn < 8) begin
         shreg = {shreg[6:0], sda};
         bitn++;
      end else begin
         if (rd && !first && sda) begin
            rd = 1'b0;
         end else if (!(rd && !first)) begin
            got.push_back(shreg);
            if (first) rd = shreg[0];
            first = 1'b0;
         end
         bitn = 0;
      end
   end

   // Only ever pulls low; release leaves the pull-up level
   always @(negedge scl) begin
      if (!active) pull = 1'b0;
      else if (bitn == 8) pull = !(rd && !first) && !(not_acknowledged_flag_data && !first);
      else pull = rd && !first && !READ_BYTE[7 - bitn];
   end
endmodule : bus_slave_model

// ==== verif/tb_top.sv ====
`timescale 1ns/10ps
module tb_top import twc_pkg::*;;
   logic        hclk;
   logic        hresetn;
   logic        hsel;
   logic        hwrite;
   logic        not_acknowledged_flag_data;
   logic [7:0]  haddr;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic [31:0] rv;
   logic        hreadyout;
   logic        hresp;
   logic        scl_o;
   logic        scl_oe;
   logic        sda_o;
   logic        sda_oe;
   logic        irq;
   logic        pull;
   logic        scl_w;
   logic        sda_w;
   logic        prev;
   int          err_total;
   int          check_count;
   int          stop_mark;
   int          cnt;
   int          lo_q[$];
   int          hi_q[$];
   logic [7:0]  ra[9] = '{OFS_CMD, OFS_SETUP, 8'h08, OFS_INNER, OFS_SHAPE, OFS_FLAGS,
                          OFS_IRQ_MAP, OFS_RX, OFS_TX};
   logic [31:0] re[9] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0000_0008, 32'h0,
                          32'h0, 32'h0};

   assign scl_w = !scl_oe;
   assign sda_w = !(sda_oe || pull);

   two_wire_controller dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .scl_i(scl_w), .scl_o(scl_o),
      .scl_oe(scl_oe), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe), .irq(irq));
   bus_slave_model slave (.scl(scl_w), .sda(sda_w), .not_acknowledged_flag_data(not_acknowledged_flag_data), .pull(pull));

   initial begin
      hclk = 1'b0;
      forever #25 hclk = ~hclk;
   end

   // Half-period lengths seen on the wire, in clock cycles
   always @(posedge hclk) begin
      if (scl_w === prev) cnt++;
      else begin
         if (prev) hi_q.push_back(cnt);
         else lo_q.push_back(cnt);
         cnt = 1;
      end
      prev = scl_w;
   end

   task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         $display("ERROR %s expected %h seen %h", name, exp, seen);
         err_total++;
      end
   endtask : check

   task ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= wr;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rv = hrdata;
   endtask : ahb

   task rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
      ahb(1'b0, a, 32'h0);
      check(name, rv, exp);
      check("response", {31'h0, hresp}, 32'h0);
   endtask : rd_chk

   // Complete stays set from enable, so wait for the stop on the wire first
   task wait_done;
      int n;
      n = 0;
      while (slave.stops == stop_mark && n < 4000) begin
         @(posedge hclk);
         n++;
      end
      check("stop count", 32'(slave.stops - stop_mark), 32'h0000_0001);
      stop_mark = slave.stops;
      n = 0;
      do begin
         ahb(1'b0, OFS_FLAGS, 32'h0);
         n++;
      end while (rv[0] !== 1'b1 && n < 100);
      check("complete", rv & 32'h0000_0001, 32'h0000_0001);
   endtask : wait_done

   task expect_bytes(input logic [7:0] e[$]);
      check("byte count", 32'(slave.got.size()), 32'(e.size()));
      foreach (e[i]) if (i < slave.got.size()) check("byte", {24'h0, slave.got[i]}, {24'h0, e[i]});
      slave.got.delete();
   endtask : expect_bytes

   task summarize;
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : summarize

   initial begin
      repeat (60000) @(posedge hclk);
      err_total++;
      $display("watchdog expired");
      summarize();
   end

   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      hwrite = 1'b0;
      haddr = 8'h00;
      htrans = 2'h0;
      hsize = HSIZE_WORD;
      hwdata = 32'h0;
      not_acknowledged_flag_data = 1'b0;
      prev = 1'b1;
      cnt = 0;
      err_total = 0;
      check_count = 0;
      stop_mark = 0;
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      foreach (ra[i]) rd_chk("reset value", ra[i], re[i]);
      check("irq reset", {31'h0, irq}, 32'h0);
      check("drive level", {30'h0, scl_o, sda_o}, 32'h0);
      ahb(1'b1, OFS_SETUP, 32'h005A_0100);
      ahb(1'b1, OFS_INNER, 32'h0000_0033);
      ahb(1'b1, OFS_SHAPE, 32'h0001_0102);
      rd_chk("setup", OFS_SETUP, 32'h005A_0100);
      rd_chk("inner", OFS_INNER, 32'h0000_0033);
      rd_chk("shape", OFS_SHAPE, 32'h0001_0102);
      // Only word writes land
      hsize <= 3'h0;
      ahb(1'b1, OFS_INNER, 32'h0000_0099);
      hsize <= HSIZE_WORD;
      rd_chk("narrow write", OFS_INNER, 32'h0000_0033);
      $display("registers done");
      ahb(1'b1, OFS_CMD, 32'h0000_0004);
      rd_chk("enabled flags", OFS_FLAGS, 32'h0000_000D);
      ahb(1'b1, OFS_IRQ_SET, 32'h0000_0001);
      repeat (3) @(negedge hclk);
      check("irq on", {31'h0, irq}, 32'h0000_0001);
      rd_chk("mask", OFS_IRQ_MAP, 32'h0000_0001);
      ahb(1'b1, OFS_IRQ_CLR, 32'h0000_0001);
      repeat (3) @(negedge hclk);
      check("irq off", {31'h0, irq}, 32'h0);
      $display("interrupt done");
      ahb(1'b1, OFS_TX, 32'h0000_00C3);
      lo_q.delete();
      hi_q.delete();
      ahb(1'b1, OFS_CMD, 32'h0000_0003);
      wait_done();
      check("write flags", rv & 32'h0000_01C7, 32'h0000_0005);
      expect_bytes('{8'hB4, 8'h33, 8'hC3});
      check("low half", 32'(lo_q[3]), 32'h0000_0007);
      check("high half", 32'(hi_q[3]), 32'h0000_0005);
      $display("write done");
      not_acknowledged_flag_data = 1'b1;
      ahb(1'b1, OFS_SETUP, 32'h005A_0000);
      ahb(1'b1, OFS_TX, 32'h0000_005E);
      ahb(1'b1, OFS_CMD, 32'h0000_0003);
      wait_done();
      check("not_acknowledged_flag flags", rv & 32'h0000_0101, 32'h0000_0101);
      rd_chk("not_acknowledged_flag cleared", OFS_FLAGS, 32'h0000_000D);
      expect_bytes('{8'hB4, 8'h5E});
      not_acknowledged_flag_data = 1'b0;
      ahb(1'b1, OFS_TX, 32'h0000_0011);
      ahb(1'b1, OFS_CMD, 32'h0000_0001);
      wait_done();
      check("underrun", rv & 32'h0000_0080, 32'h0000_0080);
      rd_chk("underrun cleared", OFS_FLAGS, 32'h0000_000D);
      expect_bytes('{8'hB4, 8'h11});
      $display("not_acknowledged_flag and underrun done");
      ahb(1'b1, OFS_SETUP, 32'h005A_1000);
      ahb(1'b1, OFS_CMD, 32'h0000_0003);
      wait_done();
      check("rx ready", rv & 32'h0000_0002, 32'h0000_0002);
      expect_bytes('{8'hB5});
      rd_chk("rx byte", OFS_RX, 32'h0000_00A5);
      ahb(1'b0, OFS_FLAGS, 32'h0);
      check("rx cleared", rv & 32'h0000_0002, 32'h0);
      $display("read done");
      ahb(1'b1, OFS_SETUP, 32'h005A_1100);
      ahb(1'b1, OFS_CMD, 32'h0000_0001);
      // Stop goes in while the second byte is still shifting
      do ahb(1'b0, OFS_FLAGS, 32'h0); while (rv[1] !== 1'b1);
      rd_chk("rx first", OFS_RX, 32'h0000_00A5);
      ahb(1'b1, OFS_CMD, 32'h0000_0002);
      wait_done();
      expect_bytes('{8'hB4, 8'h33, 8'hB5});
      rd_chk("rx last", OFS_RX, 32'h0000_00A5);
      ahb(1'b1, OFS_SETUP, 32'h005A_0300);
      ahb(1'b1, OFS_INNER, 32'h0012_3456);
      ahb(1'b1, OFS_TX, 32'h0000_0077);
      ahb(1'b1, OFS_CMD, 32'h0000_0003);
      wait_done();
      expect_bytes('{8'hB4, 8'h12, 8'h34, 8'h56, 8'h77});
      $display("inner address done");
      ahb(1'b1, OFS_SETUP, 32'h005A_0000);
      ahb(1'b1, OFS_CMD, 32'h0000_0008);
      ahb(1'b1, OFS_TX, 32'h0000_0022);
      ahb(1'b1, OFS_CMD, 32'h0000_0003);
      ahb(1'b1, OFS_CMD, 32'h0000_000C);
      repeat (400) @(posedge hclk);
      check("held while off", 32'(slave.stops), 32'(stop_mark));
      ahb(1'b1, OFS_CMD, 32'h0000_0004);
      wait_done();
      expect_bytes('{8'hB4, 8'h22});
      $display("enable done");
      ahb(1'b1, OFS_CMD, 32'h0000_0080);
      rd_chk("soft setup", OFS_SETUP, 32'h0);
      rd_chk("soft shape", OFS_SHAPE, 32'h0);
      rd_chk("soft flags", OFS_FLAGS, 32'h0000_0008);
      $display("soft reset done");
      summarize();
   end
endmodule : tb_top
